//--- design/lane_codec_map.svh
`ifndef LANE_CODEC_MAP_SVH
`define LANE_CODEC_MAP_SVH

// Running disparity encoding: 0 is negative, 1 is positive
`define RD_NEG 1'h0
`define RD_POS 1'h1
`define RD_RESET `RD_NEG

// Symbol fields: abcdei in the upper six bits, fghj in the lower four
`define SYM_6B_HI 9
`define SYM_6B_LO 4
`define SYM_4B_HI 3
`define SYM_4B_LO 0

// Byte fields: EDCBA low, HGF high
`define BYTE_5B_HI 4
`define BYTE_3B_LO 5

// Word substituted for a bad symbol (control code zero)
`define SUBST_CTRL 1'h1
`define SUBST_DATA 8'h00

// Line presence state after reset
`define PRESENCE_RESET 1'h0

// Ones in a neutral symbol
`define NEUTRAL_ONES 4'h5

`endif

//--- design/lane_codec_pkg.sv
`default_nettype none
package lane_codec_pkg;

	typedef struct packed {
		logic ctrl;
		logic [7:0] data;
	} word_t;

	typedef struct packed {
		logic meta;
		logic sync;
		logic status;
		logic notice;
	} presence_t;

	typedef struct packed {
		logic rd;
		logic [9:0] sym;
		logic valid;
	} tx_state_t;

	typedef struct packed {
		logic rd;
		word_t word;
		logic valid;
		logic disp_err;
		logic sym_err;
	} rx_state_t;

	typedef struct packed {
		presence_t pres;
		tx_state_t tx;
		rx_state_t rx;
	} codec_state_t;

endpackage
`default_nettype wire

//--- design/eightb_tenb_lane_codec.sv
`include "lane_codec_map.svh"
`default_nettype none

module eightb_tenb_lane_codec
	import lane_codec_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic tx_req,
	input wire word_t tx_word,
	output logic tx_sym_valid,
	output logic [9:0] tx_sym,
	input wire logic rx_sym_valid,
	input wire logic [9:0] rx_sym,
	output logic rx_word_valid,
	output word_t rx_word,
	output logic rx_disp_err,
	output logic rx_sym_err,
	input wire logic line_present,
	output logic presence_notice,
	output logic presence_status
);

	localparam logic [5:0] TAB6 [32] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B
	};
	localparam logic [3:0] TAB4 [8] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE
	};
	localparam logic [5:0] K28_6B = 6'h0F;
	localparam logic [3:0] ALT7_4B = 4'h7;

	// Only K28.y and K23/27/29/30.7 are legal controls
	function automatic logic ctrl_legal(input logic [7:0] d);
		logic [4:0] x;
		x = d[`BYTE_5B_HI:0];
		ctrl_legal = (x == 5'h1C) ||
			(d[7:`BYTE_3B_LO] == 3'h7 &&
			(x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E));
	endfunction

	// Returns {disparity after symbol, symbol}
	function automatic logic [10:0] encode(input logic k, input logic [7:0] d,
		input logic rd);
		logic [4:0] x;
		logic [2:0] y;
		logic [5:0] c6;
		logic [3:0] c4;
		logic unbal6, rd6, unbal4, inv4, alt7;
		x = d[`BYTE_5B_HI:0];
		y = d[7:`BYTE_3B_LO];
		c6 = (k && x == 5'h1C) ? K28_6B : TAB6[x];
		unbal6 = ($countones(c6) != 3);
		if (rd && (unbal6 || x == 5'h07)) begin
			c6 = ~c6;
		end
		rd6 = unbal6 ? ~rd : rd;
		alt7 = k || (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
			(rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E));
		c4 = (y == 3'h7 && alt7) ? ALT7_4B : TAB4[y];
		unbal4 = (y == 3'h0 || y == 3'h4 || y == 3'h7);
		if (k && (y == 3'h1 || y == 3'h2 || y == 3'h5 || y == 3'h6)) begin
			inv4 = !rd6;
		end else begin
			inv4 = rd6 && (unbal4 || y == 3'h3);
		end
		if (inv4) begin
			c4 = ~c4;
		end
		encode = {unbal4 ? ~rd6 : rd6, c6, c4};
	endfunction

	// Returns {found, word}; searches every legal code at the given disparity
	function automatic logic [9:0] lookup(input logic [9:0] s, input logic rd);
		logic [10:0] e;
		logic hit;
		logic [8:0] w;
		hit = 1'h0;
		w = 9'h000;
		for (int i = 0; i < 512; i++) begin
			e = encode(i[8], i[7:0], rd);
			if (e[9:0] == s && (!i[8] || ctrl_legal(i[7:0]))) begin
				hit = 1'h1;
				w = i[8:0];
			end
		end
		lookup = {hit, w};
	endfunction

	logic rst_meta_n, rst_n;
	codec_state_t s, next_s;
	logic [10:0] tx_enc;
	logic [9:0] rx_match, rx_other;
	logic [3:0] rx_ones;

	// Async assert, synchronous release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_n <= 1'h0;
			rst_n <= 1'h0;
		end else begin
			rst_meta_n <= 1'h1;
			rst_n <= rst_meta_n;
		end
	end

	assign tx_enc = encode(tx_word.ctrl, tx_word.data, s.tx.rd);
	assign rx_match = lookup(rx_sym, s.rx.rd);
	assign rx_other = lookup(rx_sym, ~s.rx.rd);
	assign rx_ones = 4'($countones(rx_sym));

	always_comb begin
		next_s = s;
		next_s.tx.valid = 1'h0;
		next_s.rx.valid = 1'h0;
		next_s.rx.disp_err = 1'h0;
		next_s.rx.sym_err = 1'h0;
		next_s.pres.notice = 1'h0;
		if (tx_req) begin
			next_s.tx.sym = tx_enc[9:0];
			next_s.tx.valid = 1'h1;
			next_s.tx.rd = tx_enc[10];
		end
		if (rx_sym_valid) begin
			next_s.rx.valid = 1'h1;
			if (rx_match[9]) begin
				next_s.rx.word = word_t'(rx_match[8:0]);
			end else begin
				next_s.rx.word = '{ctrl: `SUBST_CTRL, data: `SUBST_DATA};
				next_s.rx.disp_err = rx_other[9];
				next_s.rx.sym_err = !rx_other[9];
			end
			// track disparity
			// Bad symbols still steer disparity so recovery is quick
			if (rx_ones > `NEUTRAL_ONES) begin
				next_s.rx.rd = `RD_POS;
			end else if (rx_ones < `NEUTRAL_ONES) begin
				next_s.rx.rd = `RD_NEG;
			end
		end
		next_s.pres.meta = line_present;
		next_s.pres.sync = s.pres.meta;
		if (s.pres.sync != s.pres.status) begin
			next_s.pres.status = s.pres.sync;
			next_s.pres.notice = 1'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.tx.rd <= `RD_RESET;
			s.rx.rd <= `RD_RESET;
			s.pres.status <= `PRESENCE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign tx_sym_valid = s.tx.valid;
	assign tx_sym = s.tx.sym;
	assign rx_word_valid = s.rx.valid;
	assign rx_word = s.rx.word;
	assign rx_disp_err = s.rx.disp_err;
	assign rx_sym_err = s.rx.sym_err;
	assign presence_notice = s.pres.notice;
	assign presence_status = s.pres.status;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence tx_from_neg;
		tx_req && s.tx.rd == `RD_NEG;
	endsequence
	sequence tx_from_pos;
		tx_req && s.tx.rd == `RD_POS;
	endsequence
	sequence rx_bad;
		rx_sym_valid && !rx_match[9];
	endsequence

	a_tx_one_cycle: assert property (tx_req |=> tx_sym_valid)
		else $error("transmit request produced no symbol");
	a_tx_neg_variant: assert property (tx_from_neg |=> $countones(tx_sym) >= 5)
		else $error("negative disparity sent a negative symbol");
	a_tx_pos_variant: assert property (tx_from_pos |=> $countones(tx_sym) <= 5)
		else $error("positive disparity sent a positive symbol");
	a_tx_rd_follow: assert property (tx_sym_valid && $countones(tx_sym) != 5
		|-> s.tx.rd == ($countones(tx_sym) > 5))
		else $error("transmit disparity not updated");
	a_rx_subst_word: assert property (rx_bad |=> rx_word_valid && rx_word.ctrl
		&& rx_word.data == 8'h00 && (rx_disp_err ^ rx_sym_err))
		else $error("bad symbol not replaced");
	a_rx_notice: assert property (rx_sym_valid |=> rx_word_valid
		##1 (rx_word_valid == $past(rx_sym_valid)))
		else $error("received word notice wrong");
	a_rx_roundtrip: assert property (rx_word_valid && !rx_disp_err && !rx_sym_err
		|-> encode(rx_word.ctrl, rx_word.data, $past(s.rx.rd)) == {s.rx.rd, $past(rx_sym)})
		else $error("decoded word does not re-encode");
	a_rx_ctrl_legal: assert property (rx_word_valid && rx_word.ctrl && !rx_sym_err
		&& !rx_disp_err |-> ctrl_legal(rx_word.data))
		else $error("illegal control code delivered");
	a_presence_change: assert property (presence_notice
		|-> presence_status != $past(presence_status) ##1 !presence_notice)
		else $error("presence notice without change");

	// Holds matter: the lane layer may read outputs late
	sequence tx_idle;
		!tx_req;
	endsequence
	sequence tx_k28;
		tx_req && tx_word.ctrl && tx_word.data[`BYTE_5B_HI:0] == 5'h1C;
	endsequence
	sequence tx_k7;
		tx_req && tx_word.ctrl && tx_word.data[7:`BYTE_3B_LO] == 3'h7;
	endsequence
	sequence rx_idle;
		!rx_sym_valid;
	endsequence
	sequence rx_heavy;
		rx_sym_valid && $countones(rx_sym) > 5;
	endsequence
	sequence rx_light;
		rx_sym_valid && $countones(rx_sym) < 5;
	endsequence

	// Transmit side
	a_tx_ones_range: assert property (tx_sym_valid
		|-> $countones(tx_sym) >= 4 && $countones(tx_sym) <= 6)
		else $error("transmit symbol out of balance");
	a_tx_hold: assert property (tx_idle |=> !tx_sym_valid && $stable(tx_sym))
		else $error("transmit symbol moved without request");
	a_tx_rd_hold: assert property (tx_idle |=> $stable(s.tx.rd))
		else $error("transmit disparity moved without symbol");
	a_tx_k28_head: assert property (tx_k28 |=>
		tx_sym[`SYM_6B_HI:`SYM_6B_LO] == 6'h0F || tx_sym[`SYM_6B_HI:`SYM_6B_LO] == 6'h30)
		else $error("control six-bit group wrong");
	a_tx_k7_tail: assert property (tx_k7 |=>
		tx_sym[`SYM_4B_HI:`SYM_4B_LO] == 4'h7 || tx_sym[`SYM_4B_HI:`SYM_4B_LO] == 4'h8)
		else $error("control four-bit group wrong");

	// Receive side
	a_rx_err_pulse: assert property ((rx_disp_err || rx_sym_err)
		|-> rx_word_valid && !(rx_disp_err && rx_sym_err))
		else $error("receive error outside a word notice");
	a_rx_hold: assert property (rx_idle |=> !rx_word_valid && $stable(rx_word))
		else $error("received word moved without symbol");
	a_rx_rd_up: assert property (rx_heavy |=> s.rx.rd == `RD_POS)
		else $error("receive disparity not raised");
	a_rx_rd_down: assert property (rx_light |=> s.rx.rd == `RD_NEG)
		else $error("receive disparity not lowered");
	a_rx_disp_cause: assert property (rx_sym_valid && !rx_match[9] && rx_other[9]
		|=> rx_disp_err)
		else $error("wrong-disparity symbol not flagged");
	a_rx_good_clean: assert property (rx_sym_valid && rx_match[9]
		|=> !rx_disp_err && !rx_sym_err)
		else $error("legal symbol flagged as error");

	// Presence side
	a_presence_quiet: assert property (!presence_notice |-> $stable(presence_status))
		else $error("presence status moved without notice");

endmodule // eightb_tenb_lane_codec
`default_nettype wire

//--- verif/lane_far_end.sv
`default_nettype none

module lane_far_end
	import lane_codec_pkg::*;
(
	input wire logic clk,
	input wire logic tx_sym_valid,
	input wire logic [9:0] tx_sym,
	input wire logic inj,
	input wire logic [9:0] inj_sym,
	input wire logic rx_word_valid,
	input wire word_t rx_word,
	input wire logic presence_notice,
	input wire logic presence_status,
	output logic rx_sym_valid = 1'b0,
	output logic [9:0] rx_sym = 10'h000,
	output word_t last_word,
	output logic [7:0] n_stored = 8'h00,
	output logic line_absent_condition = 1'b1
);
	timeunit 1ns;
	timeprecision 1ns;

	word_t store [16];

	// Loopback transceiver
	// Idle line shows inverse so a stale symbol never looks fresh
	always @(posedge clk) begin
		rx_sym_valid <= tx_sym_valid | inj;
		rx_sym <= inj ? inj_sym : (tx_sym_valid ? tx_sym : ~rx_sym);
	end

	always @(posedge clk) begin
		if (rx_word_valid) begin
			store[n_stored[3:0]] <= rx_word;
			n_stored <= n_stored + 8'h01;
		end
	end
	assign last_word = store[4'(n_stored - 8'h01)];

	always @(posedge clk) begin
		if (presence_notice) begin
			line_absent_condition <= !presence_status;
		end
	end
endmodule // lane_far_end

`default_nettype wire

//--- verif/tb_eightb_tenb_lane_codec.sv
`default_nettype none

module tb_eightb_tenb_lane_codec
	import lane_codec_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic tx_req = 1'b0;
	word_t tx_word = '0;
	logic line_present = 1'b0;
	logic inj = 1'b0;
	logic [9:0] inj_sym = 10'h000;
	logic tx_sym_valid, rx_sym_valid, rx_word_valid, rx_disp_err, rx_sym_err;
	logic presence_notice, presence_status;
	logic [9:0] tx_sym, rx_sym;
	word_t rx_word;
	word_t last_word;
	logic [7:0] n_stored;
	logic line_absent_condition;
	int n_fail = 0;
	int total_checks = 0;

	eightb_tenb_lane_codec eightb_tenb_lane_codec_inst (
		.clk(clk), .resetn(resetn), .tx_req(tx_req), .tx_word(tx_word),
		.tx_sym_valid(tx_sym_valid), .tx_sym(tx_sym), .rx_sym_valid(rx_sym_valid),
		.rx_sym(rx_sym), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
		.rx_disp_err(rx_disp_err), .rx_sym_err(rx_sym_err), .line_present(line_present),
		.presence_notice(presence_notice), .presence_status(presence_status)
	);

	lane_far_end lane_far_end_inst (
		.clk(clk), .tx_sym_valid(tx_sym_valid), .tx_sym(tx_sym), .inj(inj),
		.inj_sym(inj_sym), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
		.presence_notice(presence_notice), .presence_status(presence_status),
		.rx_sym_valid(rx_sym_valid), .rx_sym(rx_sym), .last_word(last_word),
		.n_stored(n_stored), .line_absent_condition(line_absent_condition)
	);

	initial begin
		forever #20 clk = ~clk;
	end

	task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h got %h", name, exp, got);
		end
	endtask

	task automatic end_sim();
		if (n_fail == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Send one word, then judge the symbol and its looped-back decode
	task automatic xfer(input word_t w, input logic [9:0] s);
		tx_req = 1'b1;
		tx_word = w;
		@(negedge clk);
		tx_req = 1'b0;
		chk("tx_sym", s, tx_sym);
		chk("tx_sym_valid", 10'h001, {9'h000, tx_sym_valid});
		repeat (2) @(negedge clk);
		chk("rx_flags", 10'h004, {7'h00, rx_word_valid, rx_disp_err, rx_sym_err});
		chk("rx_word", {1'b0, w}, {1'b0, rx_word});
	endtask

	task automatic run_disparity();
		xfer({1'b0, 8'h00}, 10'h274);
		xfer({1'b1, 8'hBC}, 10'h0FA);
		xfer({1'b0, 8'h00}, 10'h18B);
		xfer({1'b1, 8'hBC}, 10'h305);
		@(negedge clk);
		chk("n_stored", 10'h004, {2'b00, n_stored});
		chk("last_word", 10'h1BC, {1'b0, last_word});
	endtask

	// Alternate .7 forms at both disparities, then a control .7
	task automatic run_alt7();
		xfer({1'b0, 8'hF1}, 10'h237);
		xfer({1'b0, 8'hEB}, 10'h348);
		xfer({1'b1, 8'hF7}, 10'h3A8);
	endtask

	task automatic rxbad(input logic [9:0] s, input logic [9:0] f);
		inj = 1'b1;
		inj_sym = s;
		@(negedge clk);
		inj = 1'b0;
		@(negedge clk);
		chk("rx_flags", f, {7'h00, rx_word_valid, rx_disp_err, rx_sym_err});
		chk("rx_word", 10'h100, {1'b0, rx_word});
	endtask

	task automatic run_rx_errors();
		rxbad(10'h000, 10'h005);
		rxbad(10'h305, 10'h006);
	endtask

	task automatic pres(input logic v);
		line_present = v;
		repeat (3) @(negedge clk);
		chk("presence", {8'h00, 1'b1, v}, {8'h00, presence_notice, presence_status});
		@(negedge clk);
		chk("presence", {8'h00, 1'b0, v}, {8'h00, presence_notice, presence_status});
		chk("line_absent", {9'h000, !v}, {9'h000, line_absent_condition});
	endtask

	initial begin
		repeat (3) @(negedge clk);
		chk("reset_out", 10'h000, {7'h00, tx_sym_valid, rx_word_valid, presence_status});
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		run_disparity();
		run_alt7();
		run_rx_errors();
		pres(1'b1);
		pres(1'b0);
		end_sim();
	end

	// Whole run is under a hundred cycles; a thousand means a hang
	initial begin
		#40000;
		n_fail++;
		end_sim();
	end
endmodule // tb_eightb_tenb_lane_codec

`default_nettype wire
